// ===== verilog/sfx_consts.svh
`ifndef SFX_CONSTS_SVH
`define SFX_CONSTS_SVH

// ----------------------------------------
// Register file layout
// ----------------------------------------
`define GPR_NUM      8
`define IDX_ACC      3'h0
`define IDX_COUNT    3'h1
`define IDX_DATA     3'h2
`define IDX_BASE     3'h3
`define IDX_SP       3'h4
`define IDX_BP       3'h5
`define IDX_SRC      3'h6
`define IDX_DST      3'h7

// ----------------------------------------
// Pointer steps and counts
// ----------------------------------------
`define STEP_BYTE    16'h0001
`define STEP_WORD    16'h0002
`define PUSH_WORDS   4'h8
`define DEPTH_ZERO   8'h00
`define DEPTH_ONE    8'h01
`define ZERO16       16'h0000

// ----------------------------------------
// Request buffer
// ----------------------------------------
`define BUF_DEPTH    2
`define BUF_FULL     2'h2
`define BUF_EMPTY    2'h0

`endif

// ===== verilog/sfx_pkg.sv
package sfx_pkg;

  typedef enum logic [2:0] {
    OP_PUSH_ALL     = 3'h0,
    OP_POP_ALL      = 3'h1,
    OP_BLOCK_IN     = 3'h2,
    OP_BLOCK_OUT    = 3'h3,
    OP_FRAME_CREATE = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    SEG_EXTRA = 2'h0,
    SEG_CODE  = 2'h1,
    SEG_STACK = 2'h2,
    SEG_DATA  = 2'h3
  } seg_sel_t;

  // Gray codes in declaration order
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_PUSH    = 4'h1,
    S_POP     = 4'h3,
    S_XFER_RD = 4'h2,
    S_XFER_WR = 4'h6,
    S_ENT_BP  = 4'h7,
    S_ENT_RD  = 4'h5,
    S_ENT_WR  = 4'h4,
    S_ENT_FP  = 4'hC,
    S_DONE    = 4'hD
  } state_t;

  typedef struct packed {
    logic        io;
    logic        write;
    logic        wide;
    logic [15:0] seg;
    logic [15:0] off;
    logic [15:0] data;
  } bus_req_t;

endpackage

// ===== verilog/req_if.sv
`timescale 1ns/1ps
interface req_if;
  import sfx_pkg::*;
  logic     valid;
  logic     ready;
  bus_req_t req;
  modport src (output valid, output req, input ready);
  modport snk (input valid, input req, output ready);
endinterface

// ===== verilog/req_buf.sv
`timescale 1ns/1ps
`include "sfx_consts.svh"
module req_buf (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  req_if.snk                in_if,
  output logic              out_valid,
  input  wire logic         out_ready,
  output sfx_pkg::bus_req_t out_req
);
  import sfx_pkg::*;

  bus_req_t   mem_q [`BUF_DEPTH];
  bus_req_t   mem_d [`BUF_DEPTH];
  logic       wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  assign in_if.ready = (cnt_q != `BUF_FULL);
  assign out_valid   = (cnt_q != `BUF_EMPTY);
  assign out_req     = mem_q[rp_q];

  always_comb begin
    push = in_if.valid && in_if.ready;
    pop  = out_valid && out_ready;
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (push) begin
      mem_d[wp_q] = in_if.req;
    end
    wp_d  = push ? ~wp_q : wp_q;
    rp_d  = pop ? ~rp_q : rp_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= `BUF_EMPTY;
    end else begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
      wp_q     <= wp_d;
      rp_q     <= rp_d;
      cnt_q    <= cnt_d;
    end
  end
endmodule

// ===== verilog/stack_frame_string_instr_exec.sv
`timescale 1ns/1ps
`include "sfx_consts.svh"
// What this block does
// - push_all stores accumulator, count, data, base, stack, frame, source, dest registers.
// - The stack_ptr word pushed is its value before the first push.
// - pop_all restores in reverse; the stacked stack_ptr word is read and discarded.
// - Segment registers, instruction pointer, status word and peripherals are never saved.
// - block_port_input reads port data_reg, writes extra_seg:dest_index, no override.
// - block_port_output reads data_seg:source_index, override allowed, writes port data_reg.
// - Pointer moves up when direction_flag clear, down when set; step 1 or 2.
// - frame_create takes a 16-bit byte count and an 8-bit nesting_depth.
// - Depth zero: push frame_base_ptr, copy stack_ptr to it, subtract byte count.
// - Push frame_base_ptr, snapshot stack_ptr, then depth-1 times lower and copy.
// - Nonzero depth pushes snapshot; always load frame_base_ptr from snapshot, subtract count.
// - Only enclosing frame pointers are copied; first display word is the previous frame.
module stack_frame_string_instr_exec (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                start,
  input  wire sfx_pkg::op_t        op,
  input  wire logic                wide,
  input  wire logic                direction_flag,
  input  wire logic                seg_ovr_en,
  input  wire sfx_pkg::seg_sel_t   seg_ovr,
  input  wire logic [15:0]         frame_size,
  input  wire logic [7:0]          nesting_depth,
  input  wire logic [7:0][15:0]    gpr_in,
  input  wire logic [15:0]         extra_seg,
  input  wire logic [15:0]         code_seg,
  input  wire logic [15:0]         stack_seg,
  input  wire logic [15:0]         data_seg,
  output logic                     busy,
  output logic                     done,
  output logic [7:0][15:0]         gpr_out,
  output logic [7:0]               gpr_wr_mask,
  output logic                     bus_valid,
  input  wire logic                bus_ready,
  output logic                     bus_io,
  output logic                     bus_write,
  output logic                     bus_wide,
  output logic [15:0]              bus_seg,
  output logic [15:0]              bus_off,
  output logic [15:0]              bus_wdata,
  input  wire logic                rsp_valid,
  input  wire logic [15:0]         rsp_rdata
);
  import sfx_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic df, input logic w);
    logic [15:0] s;
    s = w ? `STEP_WORD : `STEP_BYTE;
    ptr_step = df ? (p - s) : (p + s);
  endfunction

  function automatic bus_req_t stack_req(input logic wr, input logic [15:0] seg,
                                         input logic [15:0] off, input logic [15:0] data);
    bus_req_t r;
    r.io    = 1'b0;
    r.write = wr;
    r.wide  = 1'b1;
    r.seg   = seg;
    r.off   = off;
    r.data  = data;
    stack_req = r;
  endfunction

  function automatic logic [15:0] seg_pick(input seg_sel_t s, input logic [15:0] es,
                                           input logic [15:0] cs, input logic [15:0] ss,
                                           input logic [15:0] ds);
    case (s)
      SEG_EXTRA: seg_pick = es;
      SEG_CODE:  seg_pick = cs;
      SEG_STACK: seg_pick = ss;
      default:   seg_pick = ds;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_t      st_q, st_d;
  op_t         op_q, op_d;
  logic        wait_q, wait_d;
  logic        wide_q, wide_d;
  logic        df_q, df_d;
  logic [15:0] oseg_q, oseg_d;
  logic [15:0] size_q, size_d;
  logic [7:0]  depth_q, depth_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [2:0]  idx_q, idx_d;
  logic [15:0] entry_sp_q, entry_sp_d;
  logic [15:0] fp_q, fp_d;
  logic [15:0] tmp_q, tmp_d;
  logic [7:0]  mask_q, mask_d;
  logic        done_q, done_d;
  logic [15:0] regs_q [`GPR_NUM];
  logic [15:0] regs_d [`GPR_NUM];
  logic        issue;

  req_if       rq ();

  req_buf u_buf (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_if     (rq.snk),
    .out_valid (bus_valid),
    .out_ready (bus_ready),
    .out_req   ({bus_io, bus_write, bus_wide, bus_seg, bus_off, bus_wdata})
  );

  assign busy        = (st_q != S_IDLE);
  assign done        = done_q;
  assign gpr_wr_mask = mask_q;
  // Only request states may hand a word to the buffer
  assign issue       = (st_q != S_IDLE) && (st_q != S_DONE) && !wait_q && rq.ready;

  always_comb begin
    for (int i = 0; i < `GPR_NUM; i++) begin
      gpr_out[i] = regs_q[i];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_d       = st_q;
    op_d       = op_q;
    wait_d     = wait_q;
    wide_d     = wide_q;
    df_d       = df_q;
    oseg_d     = oseg_q;
    size_d     = size_q;
    depth_d    = depth_q;
    cnt_d      = cnt_q;
    idx_d      = idx_q;
    entry_sp_d = entry_sp_q;
    fp_d       = fp_q;
    tmp_d      = tmp_q;
    mask_d     = mask_q;
    done_d     = 1'b0;
    for (int i = 0; i < `GPR_NUM; i++) begin
      regs_d[i] = regs_q[i];
    end
    rq.valid = 1'b0;
    rq.req   = '0;
    if (issue) begin
      wait_d = 1'b1;
    end else if (wait_q && rsp_valid) begin
      wait_d = 1'b0;
    end
    case (st_q)
      S_IDLE: begin
        if (start) begin
          op_d       = op;
          wide_d     = wide;
          df_d       = direction_flag;
          // Output side may retarget its segment; input side is fixed
          oseg_d     = seg_ovr_en ? seg_pick(seg_ovr, extra_seg, code_seg, stack_seg, data_seg)
                                  : data_seg;
          size_d     = frame_size;
          depth_d    = nesting_depth;
          entry_sp_d = gpr_in[`IDX_SP];
          for (int i = 0; i < `GPR_NUM; i++) begin
            regs_d[i] = gpr_in[i];
          end
          case (op)
            OP_PUSH_ALL: begin
              st_d   = S_PUSH;
              idx_d  = `IDX_ACC;
              mask_d = 8'h10;
            end
            OP_POP_ALL: begin
              st_d   = S_POP;
              idx_d  = `IDX_DST;
              mask_d = 8'hFF;
            end
            OP_BLOCK_IN: begin
              st_d   = S_XFER_RD;
              mask_d = 8'h80;
            end
            OP_BLOCK_OUT: begin
              st_d   = S_XFER_RD;
              mask_d = 8'h40;
            end
            default: begin
              st_d   = S_ENT_BP;
              mask_d = 8'h30;
            end
          endcase
        end
      end
      S_PUSH: begin
        rq.valid = !wait_q;
        rq.req   = stack_req(1'b1, stack_seg, regs_q[`IDX_SP] - `STEP_WORD,
                             (idx_q == `IDX_SP) ? entry_sp_q : regs_q[idx_q]);
        if (issue) begin
          regs_d[`IDX_SP] = regs_q[`IDX_SP] - `STEP_WORD;
        end else if (wait_q && rsp_valid) begin
          idx_d = idx_q + 3'h1;
          if (idx_q == `IDX_DST) begin
            st_d = S_DONE;
          end
        end
      end
      S_POP: begin
        rq.valid = !wait_q;
        rq.req   = stack_req(1'b0, stack_seg, regs_q[`IDX_SP], `ZERO16);
        if (wait_q && rsp_valid) begin
          if (idx_q != `IDX_SP) begin
            regs_d[idx_q] = rsp_rdata;
          end
          regs_d[`IDX_SP] = regs_q[`IDX_SP] + `STEP_WORD;
          idx_d = idx_q - 3'h1;
          if (idx_q == `IDX_ACC) begin
            st_d = S_DONE;
          end
        end
      end
      S_XFER_RD: begin
        rq.valid      = !wait_q;
        rq.req.wide   = wide_q;
        rq.req.write  = 1'b0;
        if (op_q == OP_BLOCK_IN) begin
          rq.req.io   = 1'b1;
          rq.req.off  = regs_q[`IDX_DATA];
        end else begin
          rq.req.seg  = oseg_q;
          rq.req.off  = regs_q[`IDX_SRC];
        end
        if (wait_q && rsp_valid) begin
          tmp_d = wide_q ? rsp_rdata : {8'h00, rsp_rdata[7:0]};
          st_d  = S_XFER_WR;
        end
      end
      S_XFER_WR: begin
        rq.valid      = !wait_q;
        rq.req.wide   = wide_q;
        rq.req.write  = 1'b1;
        rq.req.data   = tmp_q;
        if (op_q == OP_BLOCK_IN) begin
          rq.req.seg  = extra_seg;
          rq.req.off  = regs_q[`IDX_DST];
        end else begin
          rq.req.io   = 1'b1;
          rq.req.off  = regs_q[`IDX_DATA];
        end
        if (wait_q && rsp_valid) begin
          if (op_q == OP_BLOCK_IN) begin
            regs_d[`IDX_DST] = ptr_step(regs_q[`IDX_DST], df_q, wide_q);
          end else begin
            regs_d[`IDX_SRC] = ptr_step(regs_q[`IDX_SRC], df_q, wide_q);
          end
          st_d = S_DONE;
        end
      end
      S_ENT_BP: begin
        rq.valid = !wait_q;
        rq.req   = stack_req(1'b1, stack_seg, regs_q[`IDX_SP] - `STEP_WORD, regs_q[`IDX_BP]);
        if (issue) begin
          regs_d[`IDX_SP] = regs_q[`IDX_SP] - `STEP_WORD;
          fp_d            = regs_q[`IDX_SP] - `STEP_WORD;
        end else if (wait_q && rsp_valid) begin
          cnt_d = depth_q - `DEPTH_ONE;
          if (depth_q == `DEPTH_ZERO) begin
            st_d = S_DONE;
          end else if (depth_q == `DEPTH_ONE) begin
            st_d = S_ENT_FP;
          end else begin
            st_d = S_ENT_RD;
          end
        end
      end
      S_ENT_RD: begin
        // Only saved frame pointers are walked, never frame contents
        rq.valid = !wait_q;
        rq.req   = stack_req(1'b0, stack_seg, regs_q[`IDX_BP] - `STEP_WORD, `ZERO16);
        if (issue) begin
          regs_d[`IDX_BP] = regs_q[`IDX_BP] - `STEP_WORD;
        end else if (wait_q && rsp_valid) begin
          tmp_d = rsp_rdata;
          st_d  = S_ENT_WR;
        end
      end
      S_ENT_WR: begin
        rq.valid = !wait_q;
        rq.req   = stack_req(1'b1, stack_seg, regs_q[`IDX_SP] - `STEP_WORD, tmp_q);
        if (issue) begin
          regs_d[`IDX_SP] = regs_q[`IDX_SP] - `STEP_WORD;
        end else if (wait_q && rsp_valid) begin
          cnt_d = cnt_q - `DEPTH_ONE;
          st_d  = (cnt_q == `DEPTH_ONE) ? S_ENT_FP : S_ENT_RD;
        end
      end
      S_ENT_FP: begin
        rq.valid = !wait_q;
        rq.req   = stack_req(1'b1, stack_seg, regs_q[`IDX_SP] - `STEP_WORD, fp_q);
        if (issue) begin
          regs_d[`IDX_SP] = regs_q[`IDX_SP] - `STEP_WORD;
        end else if (wait_q && rsp_valid) begin
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        if (op_q == OP_FRAME_CREATE) begin
          regs_d[`IDX_BP] = fp_q;
          regs_d[`IDX_SP] = regs_q[`IDX_SP] - size_q;
        end
        done_d = 1'b1;
        st_d   = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= S_IDLE;
      op_q       <= OP_PUSH_ALL;
      wait_q     <= 1'b0;
      wide_q     <= 1'b0;
      df_q       <= 1'b0;
      oseg_q     <= `ZERO16;
      size_q     <= `ZERO16;
      depth_q    <= `DEPTH_ZERO;
      cnt_q      <= `DEPTH_ZERO;
      idx_q      <= `IDX_ACC;
      entry_sp_q <= `ZERO16;
      fp_q       <= `ZERO16;
      tmp_q      <= `ZERO16;
      mask_q     <= 8'h00;
      done_q     <= 1'b0;
      for (int i = 0; i < `GPR_NUM; i++) begin
        regs_q[i] <= `ZERO16;
      end
    end else begin
      st_q       <= st_d;
      op_q       <= op_d;
      wait_q     <= wait_d;
      wide_q     <= wide_d;
      df_q       <= df_d;
      oseg_q     <= oseg_d;
      size_q     <= size_d;
      depth_q    <= depth_d;
      cnt_q      <= cnt_d;
      idx_q      <= idx_d;
      entry_sp_q <= entry_sp_d;
      fp_q       <= fp_d;
      tmp_q      <= tmp_d;
      mask_q     <= mask_d;
      done_q     <= done_d;
      for (int i = 0; i < `GPR_NUM; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic [3:0] push_cnt_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      push_cnt_q <= 4'h0;
    end else if (st_q == S_IDLE) begin
      push_cnt_q <= 4'h0;
    end else if (st_q == S_PUSH && issue) begin
      push_cnt_q <= push_cnt_q + 4'h1;
    end
  end

  a_push_reg_order: assert property (issue && st_q == S_PUSH && idx_q != `IDX_SP
    |-> idx_q == push_cnt_q[2:0] && rq.req.data == regs_q[idx_q] ##1 idx_q == $past(idx_q))
    else $error("push_all word out of order");
  a_push_sp_copy: assert property (issue && st_q == S_PUSH && idx_q == `IDX_SP
    |-> rq.req.data == entry_sp_q && rq.req.off == entry_sp_q - 16'h000A)
    else $error("push_all stack copy wrong");
  a_pop_sp_dropped: assert property (wait_q && rsp_valid && st_q == S_POP && idx_q == `IDX_SP
    |=> regs_q[`IDX_SP] == $past(regs_q[`IDX_SP]) + 16'h0002)
    else $error("pop_all overwrote stack pointer");
  a_push_eight_words: assert property (done_q && op_q == OP_PUSH_ALL
    |-> push_cnt_q == `PUSH_WORDS && gpr_wr_mask == 8'h10)
    else $error("push_all word count wrong");
  a_in_extra_seg: assert property (issue && st_q == S_XFER_WR && op_q == OP_BLOCK_IN
    |-> rq.req.seg == extra_seg && !rq.req.io && rq.req.off == regs_q[`IDX_DST])
    else $error("block input wrong segment");
  a_out_port_addr: assert property (issue && st_q == S_XFER_WR && op_q == OP_BLOCK_OUT
    |-> rq.req.io && rq.req.write && rq.req.off == regs_q[`IDX_DATA])
    else $error("block output wrong port");
  a_ptr_step_dir: assert property (wait_q && rsp_valid && st_q == S_XFER_WR && op_q == OP_BLOCK_IN
    |=> st_q == S_DONE
        && regs_q[`IDX_DST] == ($past(df_q) ? $past(regs_q[`IDX_DST]) - ($past(wide_q) ? 16'h2 : 16'h1)
                                            : $past(regs_q[`IDX_DST]) + ($past(wide_q) ? 16'h2 : 16'h1)))
    else $error("pointer step wrong");
  a_enter_frame_end: assert property (done_q && op_q == OP_FRAME_CREATE
    |-> regs_q[`IDX_BP] == entry_sp_q - 16'h0002
        && regs_q[`IDX_SP] == entry_sp_q - 16'h0002 - {7'h00, depth_q, 1'b0} - size_q)
    else $error("frame_create final pointers wrong");
  a_display_read: assert property (issue && st_q == S_ENT_RD
    |-> !rq.req.write && rq.req.seg == stack_seg ##1 regs_q[`IDX_BP] == $past(regs_q[`IDX_BP]) - 16'h0002)
    else $error("display copy read wrong");
  a_stack_predec: assert property (issue && rq.req.write && !rq.req.io && st_q != S_XFER_WR
    |-> rq.req.seg == stack_seg ##1 regs_q[`IDX_SP] == $past(regs_q[`IDX_SP]) - 16'h0002)
    else $error("push did not predecrement");

  c_push_all: cover property (done_q && op_q == OP_PUSH_ALL);
  c_pop_all: cover property (done_q && op_q == OP_POP_ALL);
  c_block_out_ovr: cover property (done_q && op_q == OP_BLOCK_OUT && oseg_q != data_seg);
  c_enter_nested: cover property (done_q && op_q == OP_FRAME_CREATE && depth_q > 8'h02);
endmodule

// ===== tb/bus_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory and port model on the processor bus
// ----------------------------------------
module bus_partner (
  input  wire logic        core_clk,
  input  wire logic        bus_valid,
  output logic             bus_ready,
  input  wire logic        bus_io,
  input  wire logic        bus_write,
  input  wire logic        bus_wide,
  input  wire logic [15:0] bus_seg,
  input  wire logic [15:0] bus_off,
  input  wire logic [15:0] bus_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  input  wire logic [3:0]  lat
);
  logic [15:0] mem [logic [31:0]];
  logic [49:0] log_q [$];
  logic [15:0] rd;
  logic [15:0] wd;
  int          cnt;
  initial begin
    bus_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_rdata = 16'h0000;
    rd = 16'h0000;
    cnt = -16;
  end
  always @(posedge core_clk) begin
    if (bus_valid && bus_ready) begin
      // Upper lane of a byte write is marked so a wrong width shows
      wd = bus_wide ? bus_wdata : {8'hA5, bus_wdata[7:0]};
      log_q.push_back({bus_io, bus_write, bus_seg, bus_off, bus_write ? wd : 16'h0000});
      if (bus_write && !bus_io) mem[{bus_seg, bus_off}] = wd;
      // Ports and unwritten places read back the inverted offset
      rd = (!bus_io && mem.exists({bus_seg, bus_off})) ? mem[{bus_seg, bus_off}] : ~bus_off;
      cnt = lat;
    end else if (cnt > -16) begin
      cnt = cnt - 1;
    end
    #1;
    rsp_valid = (cnt == 0);
    rsp_rdata = rsp_valid ? rd : ~rd;
    bus_ready = (cnt < -int'(lat));
  end
endmodule

// ===== tb/stack_frame_string_instr_exec_test.sv
`timescale 1ns/1ps
module stack_frame_string_instr_exec_test;
  import sfx_pkg::*;
  logic             core_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             start = 1'b0;
  op_t              op = OP_PUSH_ALL;
  logic             wide = 1'b0;
  logic             direction_flag = 1'b0;
  logic             seg_ovr_en = 1'b0;
  seg_sel_t         seg_ovr = SEG_EXTRA;
  logic [15:0]      frame_size = 16'h0000;
  logic [7:0]       nesting_depth = 8'h00;
  logic [7:0][15:0] gpr_in = '0;
  logic [3:0][15:0] sg = {16'h6000, 16'h3000, 16'h5000, 16'h4000};
  logic [3:0]       lat = 4'h0;
  logic             busy, done, bus_valid, bus_ready, bus_io, bus_write, bus_wide, rsp_valid;
  logic [7:0][15:0] gpr_out;
  logic [7:0]       gpr_wr_mask;
  logic [15:0]      bus_seg, bus_off, bus_wdata, rsp_rdata;
  int               err_total = 0;
  int               total_checks = 0;

  always #12.5 core_clk = ~core_clk;

  stack_frame_string_instr_exec dut_u (.core_clk, .reset_n, .start, .op, .wide, .direction_flag,
    .seg_ovr_en, .seg_ovr, .frame_size, .nesting_depth, .gpr_in, .extra_seg(sg[0]), .code_seg(sg[1]),
    .stack_seg(sg[2]), .data_seg(sg[3]), .busy, .done, .gpr_out, .gpr_wr_mask, .bus_valid, .bus_ready,
    .bus_io, .bus_write, .bus_wide, .bus_seg, .bus_off, .bus_wdata, .rsp_valid, .rsp_rdata);

  bus_partner mem_u (.core_clk, .bus_valid, .bus_ready, .bus_io, .bus_write, .bus_wide, .bus_seg,
    .bus_off, .bus_wdata, .rsp_valid, .rsp_rdata, .lat);

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [49:0] got, input logic [49:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic rq(input int k, input logic io, input logic wr, input logic [15:0] s,
                    input logic [15:0] o, input logic [15:0] d);
    chk(k < mem_u.log_q.size() ? mem_u.log_q[k] : 50'h0, {io, wr, s, o, d}, "bus request");
  endtask

  task automatic run(input op_t o);
    int n;
    mem_u.log_q.delete();
    op = o;
    start = 1'b1;
    @(posedge core_clk);
    #2 start = 1'b0;
    chk(busy, 1'b1, "busy after start");
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #2 n++;
    end
    if (n >= 400) begin
      err_total++;
      $display("BAD %0t no completion", $time);
      tally_and_finish();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_push();
    for (int i = 0; i < 8; i++) gpr_in[i] = 16'(16'h1000 + 16'h0111 * i);
    gpr_in[4] = 16'h0200;
    run(OP_PUSH_ALL);
    chk(mem_u.log_q.size(), 8, "push count");
    for (int k = 0; k < 8; k++) rq(k, 0, 1, sg[2], 16'(16'h01FE - 2 * k), gpr_in[k]);
    chk(gpr_out[4], 16'h01F0, "push sp");
    chk(gpr_wr_mask, 8'h10, "push mask");
    $display("push_all test end");
  endtask

  task automatic t_pop();
    lat = 4'h3;
    gpr_in = '0;
    gpr_in[4] = 16'h01F0;
    // Stacked stack_ptr slot made different from the final stack_ptr
    mem_u.mem[{sg[2], 16'h01F6}] = 16'h7E57;
    run(OP_POP_ALL);
    chk(mem_u.log_q.size(), 8, "pop count");
    for (int k = 0; k < 8; k++) rq(k, 0, 0, sg[2], 16'(16'h01F0 + 2 * k), 16'h0000);
    for (int i = 0; i < 8; i++) chk(gpr_out[i], i == 4 ? 16'h0200 : 16'(16'h1000 + 16'h0111 * i), "pop reg");
    chk(gpr_wr_mask, 8'hFF, "pop mask");
    lat = 4'h0;
    $display("pop_all test end");
  endtask

  task automatic t_blk();
    logic [15:0] st;
    for (int i = 0; i < 5; i++) begin
      direction_flag = i[0];
      wide = i[1];
      seg_ovr_en = (i < 4);
      seg_ovr = seg_sel_t'(i[1:0]);
      st = wide ? 16'h0002 : 16'h0001;
      gpr_in = '0;
      gpr_in[2] = 16'h0040;
      gpr_in[6] = 16'h0200;
      gpr_in[7] = 16'h0100;
      run(OP_BLOCK_IN);
      rq(0, 1, 0, 16'h0000, 16'h0040, 16'h0000);
      rq(1, 0, 1, sg[0], 16'h0100, wide ? 16'hFFBF : 16'hA5BF);
      chk(gpr_out[7], direction_flag ? 16'h0100 - st : 16'h0100 + st, "in step");
      chk(gpr_wr_mask, 8'h80, "in mask");
      run(OP_BLOCK_OUT);
      rq(0, 0, 0, i < 4 ? sg[i[1:0]] : sg[3], 16'h0200, 16'h0000);
      rq(1, 1, 1, 16'h0000, 16'h0040, wide ? 16'hFDFF : 16'hA5FF);
      chk(gpr_out[6], direction_flag ? 16'h0200 - st : 16'h0200 + st, "out step");
      chk(gpr_wr_mask, 8'h40, "out mask");
    end
    $display("block port test end");
  endtask

  task automatic t_frame(input logic [7:0] d);
    int n;
    n = 0;
    gpr_in = '0;
    gpr_in[4] = 16'h0300;
    gpr_in[5] = 16'h0380;
    frame_size = 16'h8010;
    nesting_depth = d;
    run(OP_FRAME_CREATE);
    rq(n++, 0, 1, sg[2], 16'h02FE, 16'h0380);
    for (int k = 0; k + 1 < d; k++) begin
      rq(n++, 0, 0, sg[2], 16'(16'h037E - 2 * k), 16'h0000);
      rq(n++, 0, 1, sg[2], 16'(16'h02FC - 2 * k), 16'(~(16'h037E - 2 * k)));
    end
    if (d != 0) rq(n++, 0, 1, sg[2], 16'(16'h02FE - 2 * d), 16'h02FE);
    chk(mem_u.log_q.size(), n, "frame count");
    chk(gpr_out[5], 16'h02FE, "frame base");
    chk(gpr_out[4], 16'(16'h82EE - 2 * d), "frame sp");
    chk(gpr_wr_mask, 8'h30, "frame mask");
    $display("frame_create depth %0d test end", d);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    #2 reset_n = 1'b1;
    t_push();
    t_pop();
    t_blk();
    t_frame(8'h00);
    t_frame(8'h01);
    t_frame(8'h03);
    tally_and_finish();
  end
endmodule
